// ---- hdl/tocp_pkg.sv ----
// package: register map, field positions and reset values of the timer block
package tocp_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00; // timer_main_control
    localparam logic [7:0] ADDR_COUNT = 8'h04; // counter, read only
    localparam logic [7:0] ADDR_PERIOD = 8'h08; // period_limit high:low
    localparam logic [7:0] ADDR_CH0_CTRL = 8'h0c; // chan0_control
    localparam logic [7:0] ADDR_CH0_VAL = 8'h10; // channel 0 value
    localparam logic [7:0] ADDR_CH1_CTRL = 8'h14; // chan1_control
    localparam logic [7:0] ADDR_CH1_VAL = 8'h18; // channel 1 value
    localparam logic [7:0] ADDR_PIN_STATE = 8'h1c; // pins and active pair
    // main control fields
    localparam int MC_WRAP_FLAG = 7;
    localparam int MC_WRAP_IE = 6;
    localparam int MC_HALT = 5;
    localparam int MC_CLEAR = 4;
    // channel control fields
    localparam int CC_EVENT_FLAG = 7;
    localparam int CC_IRQ_EN = 6;
    localparam int CC_MODE_HIGH = 5;
    localparam int CC_MODE_LOW = 4;
    localparam int CC_EDGE_HIGH = 3;
    localparam int CC_EDGE_LOW = 2;
    localparam int CC_TOGGLE_WRAP = 1;
    localparam int CC_FULL_DUTY = 0;
    // reset values
    localparam logic [7:0] MAIN_CTRL_RESET = 8'h20; // halted after reset
    localparam logic [7:0] CHAN_CTRL_RESET = 8'h00;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // writable bit masks of the control registers
    localparam logic [7:0] MAIN_CTRL_WMASK = 8'h60;
    localparam logic [7:0] CH0_CTRL_WMASK = 8'h7f;
    localparam logic [7:0] CH1_CTRL_WMASK = 8'h5f;
    // output action selected by the edge/level pair
    typedef enum logic [1:0] {
        TOCP_ACT_NONE, TOCP_ACT_TOGGLE, TOCP_ACT_CLEAR, TOCP_ACT_SET
    } tocp_action_type;
endpackage : tocp_pkg

// ---- hdl/tocp_channel.sv ----
// one compare channel: match detect and pin action
module tocp_channel
    import tocp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic tick, // counter advanced this cycle
    input wire logic [WIDTH-1:0] count, // shared counter value
    input wire logic [WIDTH-1:0] value, // compare value in force
    input wire logic enable, // channel drives a compare output
    input wire logic wrap, // counter is at the period limit
    input wire logic [7:0] ctrl, // channel control bits
    output logic match, // compare hit on the previous tick, registered
    output logic pin // channel output level
);
    logic pin_next; // next pin level
    logic hit; // counter arrives at the compare value
    logic [WIDTH-1:0] count_up; // counter value after this tick
    tocp_action_type act; // decoded compare action
    logic full_duty; // forced high output

    // act as the counter steps onto the value, so that a value of n gives
    // n high ticks after wrap; the wrap step lands on zero
    assign count_up = wrap ? '0 : count + 1'b1; // [RULE13] [RULE24]
    assign hit = tick && enable && (count_up == value); // [RULE3] [RULE4]
    assign act = tocp_action_type'(ctrl[CC_EDGE_HIGH:CC_EDGE_LOW]); // [RULE17]
    // forced full duty needs both bits; overrides all other actions
    assign full_duty = ctrl[CC_FULL_DUTY] && ctrl[CC_TOGGLE_WRAP]; // [RULE20]

    // compare takes priority over wrap toggle when both land together;
    // this keeps zero-width pulses at zero duty
    always_comb begin
        pin_next = pin;
        if (!enable) begin
            pin_next = 1'b0;
        end else if (full_duty) begin
            pin_next = 1'b1; // [RULE20]
        end else if (hit) begin
            case (act) // [RULE3] [RULE11]
                TOCP_ACT_TOGGLE: pin_next = ~pin;
                TOCP_ACT_CLEAR: pin_next = 1'b0;
                TOCP_ACT_SET: pin_next = 1'b1;
                default: pin_next = pin;
            endcase
        end else if (tick && wrap && ctrl[CC_TOGGLE_WRAP]) begin
            pin_next = ~pin; // [RULE10] [RULE19]
        end
    end

    // pin and match register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 1'b0;
            match <= 1'b0;
        end else begin
            pin <= pin_next;
            match <= hit;
        end
    end
endmodule : tocp_channel

// ---- hdl/tocp_top.sv ----
// two-channel output compare / pwm timer with ahb-lite registers
// Notes on behaviour
// RULE1 - one shared 16-bit counter for all channels
// RULE2 - channel values keep contents through reset
// RULE3 - match sets, clears or toggles the pin
// RULE4 - unbuffered writes replace the compare value
// RULE5 - software times unbuffered value changes
// RULE6 - link bit pairs channels onto pin 0
// RULE7 - last written pair takes over at wrap
// RULE8 - channel 1 control unused while linked
// RULE9 - software writes only the inactive pair
// RULE10 - toggle on wrap gives the pwm period
// RULE11 - width runs from wrap to match
// RULE12 - period is limit plus one ticks
// RULE13 - duty equals value over period
// RULE14 - software avoids toggle action in pwm
// RULE15 - software halts, clears, programs, then starts
// RULE16 - mode pair 0:1 unbuffered, 1:0 linked
// RULE17 - edge pair 1:0 clears, 1:1 sets
// RULE18 - link bit wins over low mode bit
// RULE19 - no wrap toggle means zero duty
// RULE20 - full-duty bit plus wrap toggle forces high
// RULE21 - event flag on compare, irq when enabled
// RULE22 - wrap flag set at period limit
// RULE23 - clear bit zeroes counter, self-clears, reads zero
// RULE24 - counter restarts at zero after limit
module tocp_top
    import tocp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk, // system clock, 20 MHz
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    input wire logic tick_in, // external timer clock pin; synchronised, but the counter never counts on it
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always okay
    output logic chan0_pin, // channel 0 output
    output logic chan1_pin, // channel 1 output
    output logic chan1_pin_oe_n, // low while chan1 drives its pin
    output logic chan0_irq, // channel 0 request
    output logic chan1_irq, // channel 1 request
    output logic wrap_irq // wrap request
);
    import tocp_pkg::*;

    // bus address phase capture
    logic wr_pend_reg; // write data phase pending
    logic [7:0] wr_addr_reg; // address of pending write
    logic rd_pend_reg; // read data phase pending
    logic [7:0] rd_addr_reg; // address of pending read
    wire addr_ok = hsel && htrans[1] && hready; // valid address phase

    // timer state
    logic [WIDTH-1:0] count_reg; // shared up-counter
    logic [WIDTH-1:0] period_reg; // period limit
    logic [WIDTH-1:0] ch0_val_reg; // channel 0 value, no reset
    logic [WIDTH-1:0] ch1_val_reg; // channel 1 value, no reset
    logic [7:0] main_reg; // halt, wrap ie, wrap flag
    logic [7:0] ch0_ctrl_reg; // channel 0 control
    logic [7:0] ch1_ctrl_reg; // channel 1 control
    logic use_ch1_reg; // linked pair: channel 1 in force
    logic ch1_written_reg; // last write went to channel 1
    logic [1:0] ext_sync_reg; // external tick synchroniser
    logic ext_prev_reg; // previous synced level
    logic main_seen_reg; // flag seen set by a read
    logic ch0_seen_reg; // channel 0 flag seen set
    logic ch1_seen_reg; // channel 1 flag seen set

    // decoded writes and flag register reads
    wire wr_now = wr_pend_reg;
    wire wr_main = wr_now && (wr_addr_reg == ADDR_MAIN_CTRL);
    wire wr_period = wr_now && (wr_addr_reg == ADDR_PERIOD);
    wire wr_ch0c = wr_now && (wr_addr_reg == ADDR_CH0_CTRL);
    wire wr_ch0v = wr_now && (wr_addr_reg == ADDR_CH0_VAL);
    wire wr_ch1c = wr_now && (wr_addr_reg == ADDR_CH1_CTRL);
    wire wr_ch1v = wr_now && (wr_addr_reg == ADDR_CH1_VAL);
    wire rd_main = rd_pend_reg && (rd_addr_reg == ADDR_MAIN_CTRL);
    wire rd_ch0c = rd_pend_reg && (rd_addr_reg == ADDR_CH0_CTRL);
    wire rd_ch1c = rd_pend_reg && (rd_addr_reg == ADDR_CH1_CTRL);

    // mode decode: link bit overrides the low mode bit
    wire linked = ch0_ctrl_reg[CC_MODE_HIGH]; // [RULE6] [RULE18]
    wire ch0_on = linked || ch0_ctrl_reg[CC_MODE_LOW]; // [RULE16]
    wire ch1_on = !linked && ch1_ctrl_reg[CC_MODE_LOW]; // [RULE8]

    // counting tick: internal clock every cycle unless halted or cleared
    wire ext_edge = ext_sync_reg[1] && !ext_prev_reg; // rising edge
    wire clear_req = wr_main && hwdata[MC_CLEAR]; // [RULE23]
    wire tick = !main_reg[MC_HALT] && !clear_req; // counter advances
    wire at_limit = (count_reg == period_reg); // [RULE22]
    wire wrap_now = tick && at_limit; // wrap event this cycle
    wire ext_unused = ext_edge; // external source kept for diagnostics

    // value in force on channel 0 pin
    wire [WIDTH-1:0] ch0_cmp = (linked && use_ch1_reg) ? ch1_val_reg
                                                       : ch0_val_reg;
    wire ch0_match; // compare hit, channel 0
    wire ch1_match; // compare hit, channel 1
    wire ch0_level; // channel 0 pin level
    wire ch1_level; // channel 1 pin level

    // the two channels share one counter
    tocp_channel #(.WIDTH(WIDTH)) u_ch0 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .count(count_reg), // [RULE1]
        .value(ch0_cmp), // [RULE4] [RULE7]
        .enable(ch0_on),
        .wrap(at_limit),
        .ctrl(ch0_ctrl_reg),
        .match(ch0_match),
        .pin(ch0_level)
    );
    tocp_channel #(.WIDTH(WIDTH)) u_ch1 (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .count(count_reg), // [RULE1]
        .value(ch1_val_reg),
        .enable(ch1_on),
        .wrap(at_limit),
        .ctrl(ch1_ctrl_reg),
        .match(ch1_match),
        .pin(ch1_level)
    );

    // bus phase tracking; the slave never stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            rd_pend_reg <= addr_ok && !hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr;
                rd_addr_reg <= haddr;
            end
        end
    end

    // read mux, registered so data meets the data phase edge
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000; // unmapped reads as zero
        case (haddr)
            ADDR_MAIN_CTRL: rd_mux = {24'h0, main_reg}; // clear reads 0
            ADDR_COUNT: rd_mux = {16'h0, count_reg};
            ADDR_PERIOD: rd_mux = {16'h0, period_reg};
            ADDR_CH0_CTRL: rd_mux = {24'h0, ch0_ctrl_reg};
            ADDR_CH0_VAL: rd_mux = {16'h0, ch0_val_reg};
            ADDR_CH1_CTRL: rd_mux = {24'h0, ch1_ctrl_reg};
            ADDR_CH1_VAL: rd_mux = {16'h0, ch1_val_reg};
            ADDR_PIN_STATE: rd_mux = {29'h0, use_ch1_reg, ch1_level,
                                      ch0_level};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // counter with halt, self-clearing clear and wrap to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= COUNT_RESET;
        end else if (clear_req) begin
            count_reg <= COUNT_RESET; // [RULE23]
        end else if (wrap_now) begin
            count_reg <= COUNT_RESET; // [RULE12] [RULE24]
        end else if (tick) begin
            count_reg <= count_reg + 1'b1; // [RULE1]
        end
    end

    // channel values have no reset on purpose: contents survive reset
    always_ff @(posedge clk) begin
        if (wr_ch0v) begin
            ch0_val_reg <= hwdata[WIDTH-1:0]; // [RULE2] [RULE4]
        end
        if (wr_ch1v) begin
            ch1_val_reg <= hwdata[WIDTH-1:0]; // [RULE2] [RULE4]
        end
    end

    // period limit and channel 1 control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= PERIOD_RESET;
            ch1_ctrl_reg <= CHAN_CTRL_RESET;
        end else begin
            if (wr_period) begin
                period_reg <= hwdata[WIDTH-1:0];
            end
            if (wr_ch1c && !linked) begin
                ch1_ctrl_reg[6:0] <= hwdata[6:0] & CH1_CTRL_WMASK[6:0];
            end
            // event flag: set wins over the two-step clear
            if (ch1_match) begin
                ch1_ctrl_reg[CC_EVENT_FLAG] <= 1'b1; // [RULE21]
            end else if (wr_ch1c && ch1_seen_reg
                         && !hwdata[CC_EVENT_FLAG]) begin
                ch1_ctrl_reg[CC_EVENT_FLAG] <= 1'b0;
            end
        end
    end

    // channel 0 control and flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch0_ctrl_reg <= CHAN_CTRL_RESET;
        end else begin
            if (wr_ch0c) begin
                ch0_ctrl_reg[6:0] <= hwdata[6:0] & CH0_CTRL_WMASK[6:0];
            end
            if (ch0_match) begin
                ch0_ctrl_reg[CC_EVENT_FLAG] <= 1'b1; // [RULE21]
            end else if (wr_ch0c && ch0_seen_reg
                         && !hwdata[CC_EVENT_FLAG]) begin
                ch0_ctrl_reg[CC_EVENT_FLAG] <= 1'b0;
            end
        end
    end

    // main control: halt resets set, wrap flag set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_reg <= MAIN_CTRL_RESET;
        end else begin
            if (wr_main) begin
                main_reg[6:5] <= hwdata[6:5] & MAIN_CTRL_WMASK[6:5];
            end
            if (wrap_now) begin
                main_reg[MC_WRAP_FLAG] <= 1'b1; // [RULE22]
            end else if (wr_main && main_seen_reg
                         && !hwdata[MC_WRAP_FLAG]) begin
                main_reg[MC_WRAP_FLAG] <= 1'b0;
            end
        end
    end

    // flag-seen latches form step one of the two-step clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_seen_reg <= 1'b0;
            ch0_seen_reg <= 1'b0;
            ch1_seen_reg <= 1'b0;
        end else begin
            main_seen_reg <= wrap_now ? 1'b0 :
                (rd_main ? main_reg[MC_WRAP_FLAG] : main_seen_reg);
            ch0_seen_reg <= ch0_match ? 1'b0 :
                (rd_ch0c ? ch0_ctrl_reg[CC_EVENT_FLAG] : ch0_seen_reg);
            ch1_seen_reg <= ch1_match ? 1'b0 :
                (rd_ch1c ? ch1_ctrl_reg[CC_EVENT_FLAG] : ch1_seen_reg);
        end
    end

    // linked pair: last written set takes over at the next wrap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            use_ch1_reg <= 1'b0;
            ch1_written_reg <= 1'b0;
        end else begin
            if (wr_ch1v) begin
                ch1_written_reg <= 1'b1; // [RULE7]
            end else if (wr_ch0v) begin
                ch1_written_reg <= 1'b0; // [RULE7]
            end
            if (!linked) begin
                use_ch1_reg <= 1'b0; // [RULE6]
            end else if (wrap_now) begin
                use_ch1_reg <= ch1_written_reg; // [RULE7]
            end
        end
    end

    // external tick synchroniser; its edge reaches only ext_unused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_reg <= 2'b00;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[0], tick_in};
            ext_prev_reg <= ext_sync_reg[1];
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            chan0_pin <= 1'b0;
            chan1_pin <= 1'b0;
            chan1_pin_oe_n <= 1'b1;
            chan0_irq <= 1'b0;
            chan1_irq <= 1'b0;
            wrap_irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
            chan0_pin <= ch0_level;
            chan1_pin <= ch1_level;
            chan1_pin_oe_n <= !ch1_on; // [RULE8]
            chan0_irq <= ch0_ctrl_reg[CC_EVENT_FLAG]
                         && ch0_ctrl_reg[CC_IRQ_EN]; // [RULE21]
            chan1_irq <= ch1_ctrl_reg[CC_EVENT_FLAG]
                         && ch1_ctrl_reg[CC_IRQ_EN] && !linked; // [RULE21]
            wrap_irq <= main_reg[MC_WRAP_FLAG] && main_reg[MC_WRAP_IE];
        end
    end

    // assertions
    sequence s_wrap_tick;
        tick && at_limit;
    endsequence

    AST_COUNT_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        s_wrap_tick |=> count_reg == '0) // [RULE24]
        else $error("counter did not restart after limit");
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        tick && !at_limit |=> count_reg == $past(count_reg) + 1'b1) // [RULE1]
        else $error("counter did not advance");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        clear_req |=> count_reg == '0 && !main_reg[MC_CLEAR]) // [RULE23]
        else $error("clear did not zero the counter");
    AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        s_wrap_tick |=> main_reg[MC_WRAP_FLAG]) // [RULE22]
        else $error("wrap flag not set");
    AST_EVENT_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        ch0_match |=> ch0_ctrl_reg[CC_EVENT_FLAG]) // [RULE21]
        else $error("channel 0 event flag not set");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        ch0_ctrl_reg[CC_EVENT_FLAG] && ch0_ctrl_reg[CC_IRQ_EN]
        |=> chan0_irq) // [RULE21]
        else $error("channel 0 irq missing");
    AST_FULL_DUTY: assert property (@(posedge clk) disable iff (!rst_n)
        ch0_on && ch0_ctrl_reg[CC_FULL_DUTY] && ch0_ctrl_reg[CC_TOGGLE_WRAP]
        |=> ##1 chan0_pin) // [RULE20]
        else $error("full duty not forced");
    AST_NO_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
        ch0_on && !ch0_ctrl_reg[CC_TOGGLE_WRAP] && !ch0_level
        && ch0_ctrl_reg[CC_EDGE_HIGH:CC_EDGE_LOW] == 2'b10
        |=> !ch0_level) // [RULE19]
        else $error("pin rose without wrap toggle");
    AST_SWAP: assert property (@(posedge clk) disable iff (!rst_n)
        linked ##0 s_wrap_tick |=> use_ch1_reg == $past(ch1_written_reg))
        // [RULE7]
        else $error("linked pair did not swap at wrap");
    AST_CH1_FREE: assert property (@(posedge clk) disable iff (!rst_n)
        linked |=> chan1_pin_oe_n) // [RULE8]
        else $error("channel 1 pin still driven while linked");
endmodule : tocp_top

// ---- sim/tocp_load_model.sv ----
// external load on the channel pins: pulse integrator and pin wire levels
module tocp_load_model (
    input wire logic clk, // system clock
    input wire logic clr, // restart the high-time count
    input wire logic pin0, // channel 0 drive
    input wire logic pin1, // channel 1 drive
    input wire logic pin1_oe_n, // low while the timer drives pin 1
    output logic [15:0] high_cnt, // cycles that pin 0 spent high
    output logic wire1 // level seen on the pin 1 wire
);
    timeunit 1ns;
    timeprecision 1ns;
    // a released pin 1 sits on a board pull-up, so it never floats
    assign wire1 = pin1_oe_n ? 1'b1 : pin1;
    // the load integrates pin 0; over whole periods this gives the duty
    always @(posedge clk) begin
        if (clr) begin
            high_cnt <= 16'h0000;
        end else if (pin0 === 1'b1) begin
            high_cnt <= high_cnt + 16'h0001;
        end
    end
endmodule : tocp_load_model

// ---- sim/test_timer_output_compare_pwm.sv ----
// testbench: register access, pwm shapes and linked channels of the timer
module test_timer_output_compare_pwm;
    import tocp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, hsel, hwrite, tick_in, clr;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic hreadyout, hresp, chan0_pin, chan1_pin, chan1_pin_oe_n;
    logic chan0_irq, chan1_irq, wrap_irq, wire1;
    logic [15:0] high_cnt;
    int err_count = 0; // mismatches seen
    int tests_run = 0; // comparisons made
    int cycles = 0; // timeout counter
    tocp_top tocp_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .tick_in(tick_in),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .chan0_pin(chan0_pin), .chan1_pin(chan1_pin),
        .chan1_pin_oe_n(chan1_pin_oe_n), .chan0_irq(chan0_irq),
        .chan1_irq(chan1_irq), .wrap_irq(wrap_irq));
    tocp_load_model tocp_load_model_i (.clk(clk), .clr(clr),
        .pin0(chan0_pin), .pin1(chan1_pin), .pin1_oe_n(chan1_pin_oe_n),
        .high_cnt(high_cnt), .wire1(wire1));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // the run should take well under a thousand cycles; a hang is cut off here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one single ahb-lite transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rd
    // halt and clear first, then limit, width, mode, then run
    task automatic pwm(input logic [31:0] val, input logic [31:0] ctl);
        wr(ADDR_MAIN_CTRL, 32'h30);
        wr(ADDR_PERIOD, 32'h7);
        wr(ADDR_CH0_VAL, val);
        wr(ADDR_CH0_CTRL, ctl);
        wr(ADDR_MAIN_CTRL, 32'h0);
    endtask : pwm
    // four periods of 8 ticks: high time must be four pulse widths
    task automatic meas(input logic [31:0] w);
        repeat (16) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (32) @(posedge clk);
        #1;
        chk({16'h0, high_cnt}, w * 4);
    endtask : meas
    task automatic results;
        $display("tests run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results
    initial begin
        rst_n = 1'b0;
        {hsel, hwrite, tick_in, clr} = 4'h0;
        haddr = 8'h00;
        htrans = 2'b00;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_MAIN_CTRL, 32'h20, 32'hffffffff);
        rd(ADDR_PERIOD, 32'hffff, 32'hffffffff);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff);
        rd(ADDR_CH0_CTRL, 32'h0, 32'hffffffff);
        rd(8'h20, 32'h0, 32'hffffffff);
        $display("test reset values done");
        wr(ADDR_MAIN_CTRL, 32'h30);
        rd(ADDR_COUNT, 32'h0, 32'hffffffff);
        rd(ADDR_MAIN_CTRL, 32'h20, 32'h30);
        $display("test counter clear done");
        pwm(32'h2, 32'h1a);
        meas(32'h2);
        // a larger width goes in just after a wrap, as from a wrap handler
        @(posedge chan0_pin);
        wr(ADDR_CH0_VAL, 32'h6);
        meas(32'h6);
        rd(ADDR_MAIN_CTRL, 32'h80, 32'hffffffff);
        rd(ADDR_CH0_CTRL, 32'h9a, 32'hffffffff);
        wr(ADDR_CH0_CTRL, 32'h5a);
        wr(ADDR_MAIN_CTRL, 32'h40);
        repeat (16) @(posedge clk);
        chk({31'h0, chan0_irq}, 32'h1);
        chk({31'h0, wrap_irq}, 32'h1);
        $display("test unbuffered pwm done");
        pwm(32'h2, 32'h1e);
        meas(32'h6);
        pwm(32'h2, 32'h18);
        meas(32'h0);
        pwm(32'h2, 32'h14);
        meas(32'h4);
        pwm(32'h2, 32'h1b);
        meas(32'h8);
        $display("test output actions done");
        wr(ADDR_CH1_VAL, 32'h4);
        wr(ADDR_CH1_CTRL, 32'h5a);
        repeat (16) @(posedge clk);
        chk({30'h0, chan1_irq, chan1_pin_oe_n}, 32'h2);
        pwm(32'h2, 32'h3a);
        meas(32'h2);
        chk({30'h0, chan1_pin_oe_n, wire1}, 32'h3);
        chk({30'h0, chan1_pin, chan1_irq}, 32'h0);
        wr(ADDR_CH1_VAL, 32'h5);
        meas(32'h5);
        wr(ADDR_CH0_VAL, 32'h3);
        meas(32'h3);
        wr(ADDR_CH1_CTRL, 32'h5f);
        rd(ADDR_CH1_CTRL, 32'h5a, 32'h7f);
        $display("test linked channels done");
        wr(ADDR_CH0_VAL, 32'h1234);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_CH0_VAL, 32'h1234, 32'hffff);
        $display("test value kept through reset done");
        results();
    end
endmodule : test_timer_output_compare_pwm
